// ==== hw/ptm_periodic_timer.sv ====
// Purpose: Periodic timer with compare, timer, PWM, single pulse, capture.
// Assumes: Pins synchronous to core_clk; APB register access.
// Notes:   Counter advances on tick while clkEn is high; clockSource is unused.
//
// Functional notes
// - Mode 11 acts as compare, pin unused.
// - Clear on A when selected, else P/overflow.
// - PWM mode on mode 10, pin 10.
// - PWM: P match clears, A sets duty.
// - 16-bit: period 65536 when P zero.
// - 10-bit: period 1024 when P zero.
// - Duty at or above period gives 100%.
// - PWM sets separate A and P flags.
// - Level, force, invert shape the PWM pin.
// - Counting continues while output is forced.
// - Single pulse is mode 10, pin 11.
// - Run rising starts counter, pulse leads.
// - A match clears run, ends pulse, flags.
// - Single pulse zeroes counter on run rise.
// - Capture mode 01, source pin selectable.
// - Capture edge decode rise/fall/both/off.
// - Capture off still lets counter run.
// - Active edge latches count into A.
// - Capture: P match resets, flags P.
// - Capture: P zero free-runs to maximum.
`timescale 1ns/1ps
module ptm_periodic_timer
	import ptm_pkg::*;
#(
	parameter int WIDTH = 16
)
(
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        clkEn,
	input  wire logic        countTick,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        timerPin0,
	input  wire logic        timerPin1,
	input  wire logic        extClockPin,
	output logic             timerOut,
	output logic             timerOutEn,
	output logic             matchAFlag,
	output logic             matchPFlag
);

	// Only the two documented widths are served; others stop elaboration.
	if (WIDTH != 10 && WIDTH != 16)
	begin : g_bad_width
		$error("WIDTH must be 10 or 16");
	end

	ptm_ctrl_t          ctrl_reg;     // Control fields.
	logic [WIDTH-1:0]   cmpA_reg;     // Compare A or captured count.
	logic [WIDTH-1:0]   cmpP_reg;     // Compare P, zero means full range.
	logic [WIDTH-1:0]   count_reg;    // Up counter.
	logic               runPrev_reg;  // Run bit one cycle earlier.
	logic               capPrev_reg;  // Capture input one cycle earlier.
	logic               extPrev_reg;  // Trigger pin one cycle earlier.
	logic               pulse_reg;    // Raw active-state of the waveform.
	logic               pin_reg;      // Registered pin level before inversion.

	logic               apbWrite;     // Write access phase.
	logic               apbRead;      // Read access phase.
	logic               runRise;      // Run bit went high.
	logic               matchA;       // Comparator A hit on a tick.
	logic               matchP;       // Comparator P hit on a tick.
	logic               atTop;        // Counter at all ones.
	logic               capIn;        // Selected capture input.
	logic               capEdge;      // Qualified capture edge.
	logic               isPwm;        // PWM output mode.
	logic               isSingle;     // Single pulse mode.
	logic               isCap;        // Capture mode.
	logic               extRise;      // Trigger pin rising.
	logic               clearCnt;     // Counter wraps to zero.
	logic               pin_next;     // Pin level before inversion.

	// Each access completes in one access cycle.
	assign apbWrite = psel && penable && pwrite;
	assign apbRead  = psel && penable && !pwrite;

	assign isCap    = ctrl_reg.modeSelect == PTM_MODE_CAP;
	assign isPwm    = ctrl_reg.modeSelect == PTM_MODE_PWM
		&& ctrl_reg.pinFunction != PTM_IO_SINGLE;
	assign isSingle = ctrl_reg.modeSelect == PTM_MODE_PWM
		&& ctrl_reg.pinFunction == PTM_IO_SINGLE;

	assign runRise = ctrl_reg.counterRun && !runPrev_reg;
	assign atTop   = &count_reg;
	assign extRise = extClockPin && !extPrev_reg;

	// Matches only count when the counter actually advances.
	assign matchA = ctrl_reg.counterRun && countTick
		&& count_reg + 1'b1 == cmpA_reg;
	// A zero P value matches on overflow, giving the full range.
	assign matchP = ctrl_reg.counterRun && countTick
		&& (cmpP_reg == '0 ? atTop : count_reg + 1'b1 == cmpP_reg);

	// Capture source: pin 0 ORed with pin 1, or the trigger pin when selected.
	assign capIn = ctrl_reg.captureSourceSelect ? extClockPin
		: (timerPin0 | timerPin1);

	// Edge decode; code 11 captures nothing.
	always_comb
	begin
		unique case (ctrl_reg.pinFunction)
			PTM_CAP_RISE: capEdge = capIn && !capPrev_reg;
			PTM_CAP_FALL: capEdge = !capIn && capPrev_reg;
			PTM_CAP_BOTH: capEdge = capIn != capPrev_reg;
			default:      capEdge = 1'b0;
		endcase
	end

	// Clear choice per mode; single pulse never wraps on compare.
	always_comb
	begin
		if (isSingle)
			clearCnt = 1'b0;
		else if (isPwm || isCap)
			clearCnt = matchP;
		else if (ctrl_reg.clearSourceSelect)
			clearCnt = matchA;
		else
			clearCnt = matchP;
	end

	// Edge history for run, capture and trigger inputs.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			runPrev_reg <= 1'b0;
			capPrev_reg <= 1'b0;
			extPrev_reg <= 1'b0;
		end
		else if (clkEn)
		begin
			runPrev_reg <= ctrl_reg.counterRun;
			capPrev_reg <= capIn;
			extPrev_reg <= extClockPin;
		end
	end

	// Control register; hardware run changes beat a software write.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			ctrl_reg <= ptm_ctrl_t'(PTM_CTRL_RST);
		else if (clkEn)
		begin
			if (apbWrite && paddr == PTM_OFF_CTRL)
				ctrl_reg <= ptm_ctrl_t'(pwdata[9:0]);
			if (isSingle && matchA)
				ctrl_reg.counterRun <= 1'b0;
			else if (isSingle && extRise && !ctrl_reg.counterRun)
				ctrl_reg.counterRun <= 1'b1;
		end
	end

	// Compare registers; a capture overrides a software write to A.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cmpA_reg <= WIDTH'(PTM_CMP_RST);
			cmpP_reg <= WIDTH'(PTM_CMP_RST);
		end
		else if (clkEn)
		begin
			if (apbWrite && paddr == PTM_OFF_CMPP)
				cmpP_reg <= pwdata[WIDTH-1:0];
			if (isCap && ctrl_reg.counterRun && capEdge)
				cmpA_reg <= count_reg;
			else if (apbWrite && paddr == PTM_OFF_CMPA)
				cmpA_reg <= pwdata[WIDTH-1:0];
		end
	end

	// Counter: zero on run rise, hold when stopped, wrap on clear.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			count_reg <= '0;
		else if (clkEn)
		begin
			if (runRise)
				count_reg <= '0;
			else if (ctrl_reg.counterRun && countTick)
			begin
				if (clearCnt)
					count_reg <= '0;
				else
					count_reg <= count_reg + 1'b1;
			end
		end
	end

	// Sticky flags; a new match wins over a clear written the same cycle.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			matchAFlag <= 1'b0;
			matchPFlag <= 1'b0;
		end
		else if (clkEn)
		begin
			// Compare A with A-clear suppresses the P flag.
			if (matchA && !isCap)
				matchAFlag <= 1'b1;
			else if (isCap && ctrl_reg.counterRun && capEdge)
				matchAFlag <= 1'b1;
			else if (apbWrite && paddr == PTM_OFF_STATUS
				&& pwdata[PTM_POS_FLAGA])
				matchAFlag <= 1'b0;
			if (matchP && (isPwm || isCap || isSingle
				|| !ctrl_reg.clearSourceSelect) && !isSingle)
				matchPFlag <= 1'b1;
			else if (apbWrite && paddr == PTM_OFF_STATUS
				&& pwdata[PTM_POS_FLAGP])
				matchPFlag <= 1'b0;
		end
	end

	// Raw waveform: active from zero until the duty count.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			pulse_reg <= 1'b0;
		else if (clkEn)
		begin
			if (isSingle)
				pulse_reg <= ctrl_reg.counterRun;
			else if (runRise || clearCnt)
				pulse_reg <= cmpA_reg != '0;
			else if (matchA && !(cmpP_reg != '0 && cmpA_reg >= cmpP_reg))
				pulse_reg <= 1'b0;
		end
	end

	// Level chosen by the pin function: forced or following the waveform.
	always_comb
	begin
		unique case (ctrl_reg.pinFunction)
			PTM_IO_INACT: pin_next = !ctrl_reg.outputLevelControl;
			PTM_IO_ACT:   pin_next = ctrl_reg.outputLevelControl;
			default:
				pin_next = pulse_reg ? ctrl_reg.outputLevelControl
					: !ctrl_reg.outputLevelControl;
		endcase
	end

	// Pin stage: force, active level, then inversion.
	// The inversion is registered too, so the pad never sees a glitch;
	// the cost is one cycle of lag after the invert bit is written.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_reg    <= 1'b0;
			timerOutEn <= 1'b0;
			timerOut   <= 1'b0;
		end
		else if (clkEn)
		begin
			// Timer mode and capture leave the pad to others.
			timerOutEn <= isPwm || isSingle;
			pin_reg    <= pin_next;
			timerOut   <= pin_next ^ ctrl_reg.outputInvert;
		end
	end

	// APB answers in the first access cycle; unmapped reads give zero.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			prdata <= 32'h0000_0000;
		else if (clkEn && psel && !penable && !pwrite)
		begin
			unique case (paddr)
				PTM_OFF_CTRL:   prdata <= 32'(ctrl_reg);
				PTM_OFF_CMPA:   prdata <= 32'(cmpA_reg);
				PTM_OFF_CMPP:   prdata <= 32'(cmpP_reg);
				PTM_OFF_COUNT:  prdata <= 32'(count_reg);
				PTM_OFF_STATUS: prdata <= {30'h0, matchPFlag, matchAFlag};
				default:        prdata <= 32'h0000_0000;
			endcase
		end
	end

	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// Single pulse: A match drops the run bit on the next edge.
	a_single_stop: assert property (@(posedge core_clk) disable iff (!resetn)
		clkEn && isSingle && matchA |=> !ctrl_reg.counterRun)
		else $error("single pulse did not stop on A match");

	// Run rise always zeroes the counter.
	a_run_zero: assert property (@(posedge core_clk) disable iff (!resetn)
		clkEn && runRise |=> count_reg == '0)
		else $error("counter not zeroed on run rise");

	// Capture latches the count.
	a_capture_latch: assert property (@(posedge core_clk) disable iff (!resetn)
		clkEn && isCap && ctrl_reg.counterRun && capEdge
		|=> cmpA_reg == $past(count_reg) && matchAFlag)
		else $error("capture did not latch count");

	// PWM P match wraps the counter.
	a_pwm_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
		clkEn && isPwm && matchP && !runRise |=> count_reg == '0)
		else $error("PWM period clear missing");

	// PWM flags the P comparator match.
	a_pwm_flags: assert property (@(posedge core_clk) disable iff (!resetn)
		clkEn && isPwm && matchP |=> matchPFlag)
		else $error("PWM P flag missing");

	// Disabled capture never latches.
	a_cap_off: assert property (@(posedge core_clk) disable iff (!resetn)
		isCap && ctrl_reg.pinFunction == 2'b11 && !apbWrite
		|=> $stable(cmpA_reg))
		else $error("capture occurred while disabled");

	// Pin not driven in timer mode.
	a_tmr_nopin: assert property (@(posedge core_clk) disable iff (!resetn)
		clkEn && ctrl_reg.modeSelect == PTM_MODE_TMR |=> !timerOutEn)
		else $error("pin driven in timer mode");

	// Forced active level in PWM mode.
	a_force_act: assert property (@(posedge core_clk) disable iff (!resetn)
		clkEn && isPwm && ctrl_reg.pinFunction == PTM_IO_ACT && !apbWrite
		|=> pin_reg == ctrl_reg.outputLevelControl)
		else $error("forced level wrong");

endmodule : ptm_periodic_timer

// ==== hw/ptm_pkg.sv ====
// Purpose: Shared constants and types for the periodic timer block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses.
package ptm_pkg;

	// Register byte offsets.
	localparam logic [7:0] PTM_OFF_CTRL   = 8'h00;
	localparam logic [7:0] PTM_OFF_CMPA   = 8'h04;
	localparam logic [7:0] PTM_OFF_CMPP   = 8'h08;
	localparam logic [7:0] PTM_OFF_COUNT  = 8'h0C;
	localparam logic [7:0] PTM_OFF_STATUS = 8'h10;

	// Control register field positions.
	localparam int PTM_POS_CCLR  = 0;
	localparam int PTM_POS_CAPTS = 1;
	localparam int PTM_POS_POL   = 2;
	localparam int PTM_POS_OC    = 3;
	localparam int PTM_POS_IO    = 4;
	localparam int PTM_POS_MODE  = 6;
	localparam int PTM_POS_RUN   = 8;
	localparam int PTM_POS_CSRC  = 9;

	// Status register field positions.
	localparam int PTM_POS_FLAGA = 0;
	localparam int PTM_POS_FLAGP = 1;

	// Reset values.
	localparam logic [9:0]  PTM_CTRL_RST = 10'h000;
	localparam logic [15:0] PTM_CMP_RST  = 16'h0000;

	// Operating mode encodings.
	localparam logic [1:0] PTM_MODE_CMP = 2'b00;
	localparam logic [1:0] PTM_MODE_CAP = 2'b01;
	localparam logic [1:0] PTM_MODE_PWM = 2'b10;
	localparam logic [1:0] PTM_MODE_TMR = 2'b11;

	// Pin function encodings for the pulse-width family.
	localparam logic [1:0] PTM_IO_INACT  = 2'b00;
	localparam logic [1:0] PTM_IO_ACT    = 2'b01;
	localparam logic [1:0] PTM_IO_PWM    = 2'b10;
	localparam logic [1:0] PTM_IO_SINGLE = 2'b11;

	// Capture edge encodings.
	localparam logic [1:0] PTM_CAP_RISE = 2'b00;
	localparam logic [1:0] PTM_CAP_FALL = 2'b01;
	localparam logic [1:0] PTM_CAP_BOTH = 2'b10;

	// Decoded control fields travel together.
	typedef struct packed {
		logic       clockSource;
		logic       counterRun;
		logic [1:0] modeSelect;
		logic [1:0] pinFunction;
		logic       outputLevelControl;
		logic       outputInvert;
		logic       captureSourceSelect;
		logic       clearSourceSelect;
	} ptm_ctrl_t;

endpackage : ptm_pkg

// ==== tb/ptm_pin_model.sv ====
// Purpose: Pin-side partner that drives the timer's three input pins.
// Assumes: Requests are given just after a rising edge of core_clk.
// Notes:   Each request bit toggles its pin once, at the next edge.
`timescale 1ns/1ps
module ptm_pin_model
(
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic [2:0] toggleReq,
	output logic      [2:0] pinLevel
);
	// Pins move only on request, so every edge the timer sees is deliberate.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			pinLevel <= 3'h0;
		else
			pinLevel <= pinLevel ^ toggleReq;
	end
endmodule : ptm_pin_model

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the periodic timer over APB.
// Assumes: The 10-bit variant, with clock enable held high.
// Notes:   Output levels are sampled on the falling edge, once settled.
`timescale 1ns/1ps
module testbench
	import ptm_pkg::*;
;
	logic        core_clk = 0, resetn = 0;
	logic        psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd, c1;
	logic        pready, pslverr, timerOut, timerOutEn;
	logic        countTick = 1'b1;
	logic        matchAFlag, matchPFlag;
	logic [2:0]  toggleReq = 3'h0, pins;
	logic [1:0]  capExp [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
	logic [7:0]  offs [6] = '{PTM_OFF_CTRL, PTM_OFF_CMPA, PTM_OFF_CMPP,
		PTM_OFF_COUNT, PTM_OFF_STATUS, 8'h14};
	int          err_total = 0, checks = 0, hi;

	always #50 core_clk = ~core_clk;

	ptm_periodic_timer #(.WIDTH(10)) dut_u (.core_clk(core_clk),
		.resetn(resetn), .clkEn(1'b1), .countTick(countTick), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timerPin0(pins[0]), .timerPin1(pins[1]), .extClockPin(pins[2]),
		.timerOut(timerOut), .timerOutEn(timerOutEn),
		.matchAFlag(matchAFlag), .matchPFlag(matchPFlag));
	ptm_pin_model pin_u (.core_clk(core_clk), .resetn(resetn),
		.toggleReq(toggleReq), .pinLevel(pins));

	// One APB transfer; the request is held until pready is seen high.
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Range compare, used where only a bound of a count is fixed.
	task chkr(input string n, input int lo, input int up,
		input logic [31:0] g);
		checks++;
		if ($isunknown(g) || !(g >= lo && g <= up))
		begin
			err_total++;
			$display("CHECK FAILED %s expected %0d..%0d seen %h", n, lo, up, g);
		end
	endtask : chkr

	// Control word: run, mode, pin function, level, invert, source, clear.
	function logic [31:0] ctl(input logic [1:0] m, input logic [1:0] io,
		input logic oc, input logic pol, input logic cs, input logic cc,
		input logic run);
		return {23'h00_0000, run, m, io, oc, pol, cs, cc};
	endfunction : ctl

	// Counts the cycles in which the pin is high.
	task meas(input int n);
		hi = 0;
		repeat (n)
		begin
			@(negedge core_clk);
			// An unknown level spoils the count, so no test passes on it.
			if (timerOut === 1'b1)
				hi++;
			else if (timerOut !== 1'b0)
				hi += 4096;
		end
	endtask : meas

	// One edge on pin i, then time for the input to be seen.
	task pulse(input int i);
		@(posedge core_clk);
		toggleReq <= 3'(1 << i);
		@(posedge core_clk);
		toggleReq <= 3'h0;
		repeat (4) @(posedge core_clk);
	endtask : pulse

	// Stops the timer and clears both sticky flags.
	task stop_clr;
		apb(1, PTM_OFF_CTRL, 32'h0000_0000);
		apb(1, PTM_OFF_STATUS, 32'h0000_0003);
	endtask : stop_clr

	task end_sim;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	// Watchdog, well beyond the few thousand cycles the tests need.
	initial
	begin
		#(100 * 30000);
		err_total++;
		end_sim();
	end

	initial
	begin
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		foreach (offs[i])
		begin
			apb(0, offs[i], 32'h0000_0000);
			chk("reset", 32'h0000_0000, rd);
			chk("slvErr", 1'b0, pslverr);
		end
		// Timer mode, clearing on A above P: only the A flag may rise.
		apb(1, PTM_OFF_CMPA, 32'h0000_0005);
		apb(1, PTM_OFF_CMPP, 32'h0000_0003);
		apb(1, PTM_OFF_CTRL, ctl(2'h3, 2'h0, 0, 0, 0, 1, 1));
		repeat (40) @(posedge core_clk);
		@(negedge core_clk);
		chk("tmrFlags", 2'h2, {matchAFlag, matchPFlag});
		chk("tmrEn", 1'b0, timerOutEn);
		apb(0, PTM_OFF_COUNT, 32'h0000_0000);
		chkr("tmrCount", 0, 5, rd);
		// PWM, period 8 and duty 3; the clear select is set and ignored.
		stop_clr();
		apb(1, PTM_OFF_CMPP, 32'h0000_0008);
		apb(1, PTM_OFF_CMPA, 32'h0000_0003);
		apb(1, PTM_OFF_CTRL, ctl(2'h2, 2'h2, 1, 0, 0, 1, 1));
		repeat (4) @(posedge core_clk);
		meas(32);
		chk("duty", 12, hi);
		chk("pwmFlags", 2'h3, {matchAFlag, matchPFlag});
		chk("pwmEn", 1'b1, timerOutEn);
		apb(1, PTM_OFF_CMPA, 32'h0000_0009);
		repeat (10) @(posedge core_clk);
		meas(32);
		chk("full", 32, hi);
		apb(1, PTM_OFF_CTRL, 32'h0000_0000);
		apb(1, PTM_OFF_CTRL, ctl(2'h2, 2'h2, 1, 1, 0, 0, 1));
		// The pin stage still shows the stopped level for one cycle.
		repeat (2) @(posedge core_clk);
		meas(32);
		chk("invert", 0, hi);
		// Duty below the period again, so both comparators keep matching.
		apb(1, PTM_OFF_CMPA, 32'h0000_0003);
		// Forced levels; counting and flags must carry on regardless.
		for (int io = 0; io < 2; io++)
		begin
			stop_clr();
			apb(1, PTM_OFF_CTRL, ctl(2'h2, 2'(io), 1, 0, 0, 0, 1));
			repeat (2) @(posedge core_clk);
			meas(32);
			chk("forced", io * 32, hi);
			chk("forceFlags", 2'h3, {matchAFlag, matchPFlag});
		end
		// Zero period value gives the full 1024-count period.
		stop_clr();
		apb(1, PTM_OFF_CMPP, 32'h0000_0000);
		apb(1, PTM_OFF_CMPA, 32'h0000_0200);
		apb(1, PTM_OFF_CTRL, ctl(2'h2, 2'h2, 1, 0, 0, 0, 1));
		repeat (4) @(posedge core_clk);
		meas(2048);
		chk("p1024", 1024, hi);
		// Single pulse of width 20, started from the external pin.
		stop_clr();
		apb(1, PTM_OFF_CMPA, 32'h0000_0014);
		apb(1, PTM_OFF_CTRL, ctl(2'h2, 2'h3, 1, 0, 0, 0, 0));
		@(posedge core_clk);
		toggleReq <= 3'h4;
		@(posedge core_clk);
		toggleReq <= 3'h0;
		meas(40);
		chkr("pulse", 19, 22, hi);
		chk("spFlag", 1'b1, matchAFlag);
		pulse(2);
		apb(0, PTM_OFF_CTRL, 32'h0000_0000);
		chk("runOff", 1'b0, rd[8]);
		apb(0, PTM_OFF_COUNT, 32'h0000_0000);
		c1 = rd;
		apb(1, PTM_OFF_CTRL, ctl(2'h2, 2'h3, 1, 0, 0, 0, 1));
		meas(40);
		chkr("pulse2", 19, 22, hi);
		apb(0, PTM_OFF_COUNT, 32'h0000_0000);
		chk("restart", c1, rd);
		// Capture from the external pin, each edge selection in turn.
		for (int io = 0; io < 4; io++)
		begin
			stop_clr();
			apb(1, PTM_OFF_CTRL, ctl(2'h1, 2'(io), 0, 0, 1, 0, 1));
			repeat (20) @(posedge core_clk);
			pulse(2);
			chk("capRise", capExp[io][1], matchAFlag);
			if (capExp[io][1])
			begin
				apb(0, PTM_OFF_CMPA, 32'h0000_0000);
				chkr("capVal", 20, 40, rd);
			end
			apb(1, PTM_OFF_STATUS, 32'h0000_0001);
			pulse(2);
			chk("capFall", capExp[io][0], matchAFlag);
		end
		apb(0, PTM_OFF_COUNT, 32'h0000_0000);
		chkr("capRun", 33, 37, rd);
		// With the tick held low the counter must not move.
		countTick <= 1'b0;
		apb(0, PTM_OFF_COUNT, 32'h0000_0000);
		c1 = rd;
		repeat (5) @(posedge core_clk);
		apb(0, PTM_OFF_COUNT, 32'h0000_0000);
		chk("tickHold", c1, rd);
		countTick <= 1'b1;
		// Timer pin source with a period of 5.
		stop_clr();
		apb(1, PTM_OFF_CMPP, 32'h0000_0005);
		apb(1, PTM_OFF_CTRL, ctl(2'h1, 2'h0, 0, 0, 0, 0, 1));
		pulse(0);
		// The first P match lands on the last edge of the pulse task.
		@(negedge core_clk);
		chk("capFlags", 2'h3, {matchAFlag, matchPFlag});
		apb(0, PTM_OFF_COUNT, 32'h0000_0000);
		chkr("capWrap", 0, 5, rd);
		end_sim();
	end
endmodule : testbench
